//--- pkg/nfc_regs.svh
// constants of the nand flash host controller
`ifndef NFC_REGS_SVH
`define NFC_REGS_SVH
`define NFC_CMD_READ      8'h00
`define NFC_CMD_READ_GO   8'h30
`define NFC_CMD_PROG      8'h80
`define NFC_CMD_PROG_GO   8'h10
`define NFC_CMD_ERASE     8'h60
`define NFC_CMD_ERASE_GO  8'hd0
`define NFC_PAGE_BYTES    2112
`define NFC_PAGES         64
`define NFC_BLOCKS        1024
`define NFC_CLK_NS        20
`define NFC_WP_NS         25
`define NFC_WH_NS         15
`define NFC_RP_NS         35
`define NFC_REH_NS        15
`define NFC_WB_NS         200
`define NFC_WW_NS         100
`define NFC_CYC_UP(ns)    (((ns) + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`endif

//--- pkg/nfc_pkg.sv
// types of the nand flash host controller
package nfc_pkg;
	typedef enum logic [1:0] {
		NFC_OP_READ  = 2'b00,
		NFC_OP_PROG  = 2'b01,
		NFC_OP_ERASE = 2'b10
	} nfc_op_t;
	typedef enum logic [1:0] {
		NFC_CY_CMD  = 2'b00,
		NFC_CY_ADDR = 2'b01,
		NFC_CY_DATA = 2'b10
	} nfc_cycle_t;
endpackage

//--- src/nfc_strobe.sv
// one strobed bus cycle: low phase then high phase, then done
`timescale 1ns/10ps
module nfc_strobe #(
	parameter int LOW_CYC  = 2,
	parameter int HIGH_CYC = 1
) (
	input  wire logic clock_i,
	input  wire logic rst_i,
	input  wire logic start_i,
	output logic      strobe_n_o,
	output logic      done_o
);
	// elaboration check: the phase counter is four bits wide
	if (LOW_CYC < 1 || HIGH_CYC < 1 || LOW_CYC > 15 || HIGH_CYC > 15) begin : g_bad_phase
		$error("nfc_strobe: phase counts out of range");
	end
	logic [3:0] cnt_r;
	logic       low_r;
	logic       busy_r;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			cnt_r      <= 4'h0;
			low_r      <= 1'b0;
			busy_r     <= 1'b0;
			strobe_n_o <= 1'b1;
			done_o     <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!busy_r) begin
				if (start_i) begin
					busy_r     <= 1'b1;
					low_r      <= 1'b1;
					strobe_n_o <= 1'b0;
					cnt_r      <= 4'(LOW_CYC - 1);
				end
			end else if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end else if (low_r) begin
				low_r      <= 1'b0;
				strobe_n_o <= 1'b1;
				cnt_r      <= 4'(HIGH_CYC - 1);
			end else begin
				busy_r <= 1'b0;
				done_o <= 1'b1;
			end
		end
	end
endmodule

//--- src/nfc_host.sv
// host controller driving a nand flash through its pins
`timescale 1ns/10ps
`include "nfc_regs.svh"
module nfc_host import nfc_pkg::*; #(
	parameter int COL_W = 12,
	parameter int ROW_W = 16,
	parameter int BUSY_WAIT_CYC = `NFC_CYC_UP(`NFC_WB_NS)
) (
	input  wire logic             clock_i,
	input  wire logic             rst_i,
	// user request
	input  wire logic             req_valid_i,
	output logic                  req_ready_o,
	input  wire nfc_op_t          req_op_i,
	input  wire logic [COL_W-1:0] req_col_i,
	input  wire logic [ROW_W-1:0] req_row_i,
	input  wire logic [11:0]      req_len_i,
	input  wire logic             guard_en_i,
	// write data stream
	input  wire logic             wr_valid_i,
	output logic                  wr_ready_o,
	input  wire logic [7:0]       wr_data_i,
	// read data stream
	output logic                  rd_valid_o,
	output logic [7:0]            rd_data_o,
	output logic                  done_o,
	output logic                  refused_o,
	// flash pins
	output logic                  chip_select_n_o,
	output logic                  command_latch_enable_o,
	output logic                  address_latch_enable_o,
	output logic                  write_strobe_n_o,
	output logic                  output_strobe_n_o,
	output logic                  program_guard_n_o,
	input  wire logic             ready_busy_n_i,
	input  wire logic [7:0]       shared_bus_i,
	output logic [7:0]            shared_bus_o,
	output logic                  shared_bus_oe_o
);
	// elaboration check: fixed address split, eight-bit wait counter
	if (COL_W != 12 || ROW_W != 16
			|| BUSY_WAIT_CYC < 1 || BUSY_WAIT_CYC > 255) begin : g_bad_cfg
		$error("nfc_host: unsupported geometry");
	end
	localparam int WCYC_LO = `NFC_CYC_UP(`NFC_WP_NS);
	localparam int WCYC_HI = `NFC_CYC_UP(`NFC_WH_NS) + 1;
	localparam int RCYC_LO = `NFC_CYC_UP(`NFC_RP_NS) + 1;
	localparam int RCYC_HI = `NFC_CYC_UP(`NFC_REH_NS);
	localparam int WW_CYC  = `NFC_CYC_UP(`NFC_WW_NS);

	typedef enum logic [3:0] {
		NFC_ST_IDLE  = 4'b0000,
		NFC_ST_CMD1  = 4'b0001,
		NFC_ST_ADDR  = 4'b0010,
		NFC_ST_WDATA = 4'b0011,
		NFC_ST_CMD2  = 4'b0100,
		NFC_ST_WAITB = 4'b0101,
		NFC_ST_WAITR = 4'b0110,
		NFC_ST_RDATA = 4'b0111,
		NFC_ST_GUARD = 4'b1000
	} nfc_state_t;

	// address byte k of a full address, column first then row
	function automatic logic [7:0] addr_byte(input logic [1:0] k,
			input logic [COL_W-1:0] col, input logic [ROW_W-1:0] row);
		case (k)
			2'd0:    addr_byte = col[7:0];
			2'd1:    addr_byte = {4'h0, col[11:8]};
			2'd2:    addr_byte = row[7:0];
			default: addr_byte = row[15:8];
		endcase
	endfunction

	nfc_state_t state_r;
	nfc_op_t    op_r;
	logic [COL_W-1:0] col_r;
	logic [ROW_W-1:0] row_r;
	logic [11:0] left_r;
	logic [1:0]  acnt_r;
	logic [7:0]  wait_r;
	logic        w_start;
	logic        w_done;
	logic        r_start;
	logic        r_done;
	logic        busy_seen_r;
	logic [7:0]  rd_hold_r;

	nfc_strobe #(.LOW_CYC(WCYC_LO), .HIGH_CYC(WCYC_HI)) u_wr (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.start_i    (w_start),
		.strobe_n_o (write_strobe_n_o),
		.done_o     (w_done)
	);
	nfc_strobe #(.LOW_CYC(RCYC_LO), .HIGH_CYC(RCYC_HI)) u_rd (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.start_i    (r_start),
		.strobe_n_o (output_strobe_n_o),
		.done_o     (r_done)
	);

	// a cycle is launched when the state enters it or its previous one completes
	logic launch_r;
	assign w_start = launch_r && (state_r == NFC_ST_CMD1 || state_r == NFC_ST_ADDR
		|| state_r == NFC_ST_CMD2 || (state_r == NFC_ST_WDATA && wr_valid_i));
	assign r_start = launch_r && state_r == NFC_ST_RDATA;
	assign wr_ready_o = w_start && state_r == NFC_ST_WDATA;
	assign req_ready_o = state_r == NFC_ST_IDLE;

	// ===============================================
	// sequencer
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_r  <= NFC_ST_IDLE;
			op_r     <= NFC_OP_READ;
			col_r    <= '0;
			row_r    <= '0;
			left_r   <= 12'h000;
			acnt_r   <= 2'd0;
			wait_r   <= 8'h00;
			launch_r <= 1'b0;
			done_o   <= 1'b0;
			refused_o <= 1'b0;
			busy_seen_r <= 1'b0;
		end else begin
			done_o    <= 1'b0;
			refused_o <= 1'b0;
			case (state_r)
				NFC_ST_IDLE: begin
					if (req_valid_i) begin
						op_r   <= req_op_i;
						col_r  <= req_col_i;
						row_r  <= req_row_i;
						left_r <= req_len_i;
						if (req_op_i != NFC_OP_READ && guard_en_i) begin
							refused_o <= 1'b1;
						end else if (req_op_i != NFC_OP_READ) begin
							state_r <= NFC_ST_GUARD;
							wait_r  <= 8'(WW_CYC);
						end else begin
							state_r  <= NFC_ST_CMD1;
							launch_r <= 1'b1;
						end
					end
				end
				NFC_ST_GUARD: begin
					if (wait_r == 8'h00) begin
						state_r  <= NFC_ST_CMD1;
						launch_r <= 1'b1;
					end else begin
						wait_r <= wait_r - 8'h01;
					end
				end
				NFC_ST_CMD1: begin
					launch_r <= 1'b0;
					if (w_done) begin
						state_r  <= NFC_ST_ADDR;
						launch_r <= 1'b1;
						acnt_r   <= (op_r == NFC_OP_ERASE) ? 2'd2 : 2'd0;
					end
				end
				NFC_ST_ADDR: begin
					launch_r <= 1'b0;
					if (w_done) begin
						launch_r <= 1'b1;
						acnt_r   <= acnt_r + 2'd1;
						if (acnt_r == 2'd3) begin
							if (op_r == NFC_OP_PROG && left_r != 12'h000)
								state_r <= NFC_ST_WDATA;
							else
								state_r <= NFC_ST_CMD2;
						end
					end
				end
				NFC_ST_WDATA: begin
					if (w_start)
						launch_r <= 1'b0;
					if (w_done) begin
						launch_r <= 1'b1;
						left_r   <= left_r - 12'h001;
						if (left_r == 12'h001)
							state_r <= NFC_ST_CMD2;
					end
				end
				NFC_ST_CMD2: begin
					launch_r <= 1'b0;
					if (w_done) begin
						state_r     <= NFC_ST_WAITB;
						wait_r      <= 8'(BUSY_WAIT_CYC);
						busy_seen_r <= 1'b0;
					end
				end
				NFC_ST_WAITB: begin
					// device may take up to the busy delay to pull the line low
					if (!ready_busy_n_i)
						busy_seen_r <= 1'b1;
					// once busy has been seen there is no need to wait out the delay
					if (wait_r == 8'h00 || busy_seen_r)
						state_r <= NFC_ST_WAITR;
					else
						wait_r <= wait_r - 8'h01;
				end
				NFC_ST_WAITR: begin
					if (ready_busy_n_i) begin
						if (op_r == NFC_OP_READ && left_r != 12'h000) begin
							state_r  <= NFC_ST_RDATA;
							launch_r <= 1'b1;
						end else begin
							state_r <= NFC_ST_IDLE;
							done_o  <= 1'b1;
						end
					end
				end
				NFC_ST_RDATA: begin
					launch_r <= 1'b0;
					if (r_done) begin
						left_r <= left_r - 12'h001;
						if (left_r == 12'h001) begin
							state_r <= NFC_ST_IDLE;
							done_o  <= 1'b1;
						end else begin
							launch_r <= 1'b1;
						end
					end
				end
				default: state_r <= NFC_ST_IDLE;
			endcase
		end
	end

	// ===============================================
	// read data capture, sampled late in the low phase
	// the device lets the bus go soon after the strobe rises, so the byte is
	// held from the last edge of the low phase and handed over once the cycle ends
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rd_hold_r  <= 8'h00;
			rd_valid_o <= 1'b0;
			rd_data_o  <= 8'h00;
		end else begin
			rd_valid_o <= 1'b0;
			if (!output_strobe_n_o)
				rd_hold_r <= shared_bus_i;
			if (state_r == NFC_ST_RDATA && r_done) begin
				rd_valid_o <= 1'b1;
				rd_data_o  <= rd_hold_r;
			end
		end
	end

	// ===============================================
	// latch enables, bus drive and chip select
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			command_latch_enable_o <= 1'b0;
			address_latch_enable_o <= 1'b0;
			shared_bus_o           <= 8'h00;
			shared_bus_oe_o        <= 1'b0;
			chip_select_n_o        <= 1'b1;
			program_guard_n_o      <= 1'b0;
		end else begin
			program_guard_n_o <= !guard_en_i && state_r != NFC_ST_IDLE
				? 1'b1 : !guard_en_i && program_guard_n_o;
			chip_select_n_o <= (state_r == NFC_ST_IDLE);
			if (w_start) begin
				shared_bus_oe_o        <= 1'b1;
				command_latch_enable_o <= (state_r == NFC_ST_CMD1 || state_r == NFC_ST_CMD2);
				address_latch_enable_o <= (state_r == NFC_ST_ADDR);
				case (state_r)
					NFC_ST_CMD1: shared_bus_o <= (op_r == NFC_OP_READ) ? `NFC_CMD_READ :
						(op_r == NFC_OP_PROG) ? `NFC_CMD_PROG : `NFC_CMD_ERASE;
					NFC_ST_CMD2: shared_bus_o <= (op_r == NFC_OP_READ) ? `NFC_CMD_READ_GO :
						(op_r == NFC_OP_PROG) ? `NFC_CMD_PROG_GO : `NFC_CMD_ERASE_GO;
					NFC_ST_ADDR: shared_bus_o <= addr_byte(acnt_r, col_r, row_r);
					default:     shared_bus_o <= wr_data_i;
				endcase
			end else if (w_done) begin
				shared_bus_oe_o        <= 1'b0;
				command_latch_enable_o <= 1'b0;
				address_latch_enable_o <= 1'b0;
			end
		end
	end
endmodule

//--- verification/nfc_host_checker.sv
// assertions on the nand flash host controller ports
`timescale 1ns/10ps
module nfc_host_checker import nfc_pkg::*; (
	input wire logic    clock_i,
	input wire logic    rst_i,
	input wire logic    req_valid_i,
	input wire logic    req_ready_o,
	input wire logic    guard_en_i,
	input wire logic    rd_valid_o,
	input wire logic    done_o,
	input wire logic    refused_o,
	input wire logic    chip_select_n_o,
	input wire logic    command_latch_enable_o,
	input wire logic    address_latch_enable_o,
	input wire logic    write_strobe_n_o,
	input wire logic    output_strobe_n_o,
	input wire logic    program_guard_n_o,
	input wire logic    ready_busy_n_i,
	input wire logic    shared_bus_oe_o,
	input wire nfc_op_t req_op_i
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// ==========================
	// pin relations
	latch_excl_a: assert property (command_latch_enable_o |-> !address_latch_enable_o)
		else $error("both latches high");
	write_drive_a: assert property (!write_strobe_n_o |-> shared_bus_oe_o && output_strobe_n_o)
		else $error("write strobe without bus");
	read_release_a: assert property (!output_strobe_n_o |-> !shared_bus_oe_o)
		else $error("bus driven while reading");
	busy_select_a: assert property (!ready_busy_n_i |-> !chip_select_n_o)
		else $error("select dropped while busy");
	idle_select_a: assert property (req_ready_o ##1 req_ready_o |-> chip_select_n_o)
		else $error("select low while idle");
	guard_refuse_a: assert property (req_valid_i && req_ready_o && guard_en_i &&
		req_op_i != NFC_OP_READ |=> refused_o) else $error("guarded op not refused");
	guard_pin_a: assert property (guard_en_i && req_ready_o ##1 guard_en_i |->
		!program_guard_n_o) else $error("guard pin released");
	done_ready_a: assert property (done_o |-> ready_busy_n_i)
		else $error("done while busy");
	byte_spacing_a: assert property (rd_valid_o |=> !rd_valid_o [*3])
		else $error("read bytes too close");
	cover property (refused_o);
	cover property (rd_valid_o ##6 rd_valid_o);
	cover property (done_o);
endmodule

bind nfc_host nfc_host_checker i_nfc_host_checker (.*);

//--- verification/nfc_flash_model.sv
// behavioural nand flash device answering the host pins
`timescale 1ns/10ps
module nfc_flash_model #(
	parameter int BUSY_NS = 1000
) (
	input wire logic cs_n_i,
	input wire logic cle_i,
	input wire logic ale_i,
	input wire logic we_n_i,
	input wire logic output_strobe_n_i,
	input wire logic guard_n_i,
	input wire logic [7:0] shared_bus_i,
	output logic [7:0] shared_bus_o,
	output logic busy_pull_o
);
	logic [7:0] mem[int], pbuf[int], a[4], cmd;
	int acnt, col, row, ks[$];
	initial begin
		busy_pull_o = 0;
		shared_bus_o = 8'h5a;
	end
	task automatic go_busy;
		#100 busy_pull_o = 1;
		#(BUSY_NS) busy_pull_o = 0;
	endtask
	// ==========================
	// strobed writes, ignored while busy
	always @(posedge we_n_i) if (!cs_n_i && !busy_pull_o) begin
		if (cle_i) begin
			cmd = shared_bus_i;
			if (cmd == 8'h00 || cmd == 8'h80 || cmd == 8'h60) acnt = 0;
			if (cmd == 8'h80) pbuf.delete();
			if (cmd == 8'h30) fork go_busy; join_none
			if ((cmd == 8'h10 || cmd == 8'hd0) && guard_n_i) begin
				ks.delete();
				foreach (mem[k]) if (cmd == 8'hd0 && k / 262144 == row / 64) ks.push_back(k);
				foreach (ks[i]) mem.delete(ks[i]);
				if (cmd == 8'h10) foreach (pbuf[k]) mem[row * 4096 + k] = pbuf[k];
				fork go_busy; join_none
			end
		end else if (ale_i) begin
			a[acnt % 4] = shared_bus_i;
			acnt++;
			col = {a[1][3:0], a[0]};
			row = (cmd == 8'h60) ? {a[1], a[0]} : {a[3], a[2]};
		end else begin
			pbuf[col] = shared_bus_i;
			col++;
		end
	end
	// ==========================
	// serial output, bus scrambled once hold time ends
	always @(negedge output_strobe_n_i) if (!cs_n_i) begin
		shared_bus_o <= #20 mem.exists(row * 4096 + col) ? mem[row * 4096 + col] : 8'hff;
		col++;
	end
	always @(posedge output_strobe_n_i) shared_bus_o <= #10 ~shared_bus_o;
endmodule

//--- verification/nfc_host_tb.sv
// self-checking bench of the nand flash host controller
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH %0t %s", $time, "value differs"); end end
module nfc_host_tb import nfc_pkg::*; ;
	logic clock_i = 0, rst_i = 1, req_valid_i = 0, guard_en_i = 0, wr_valid_i = 0, took = 0;
	logic busy_pull, req_ready_o, wr_ready_o, rd_valid_o, done_o, refused_o, chip_select_n_o;
	logic command_latch_enable_o, address_latch_enable_o, write_strobe_n_o;
	logic output_strobe_n_o, program_guard_n_o, shared_bus_oe_o;
	nfc_op_t req_op_i = NFC_OP_READ;
	logic [11:0] req_col_i = 0, req_len_i = 0;
	logic [15:0] req_row_i = 0;
	logic [7:0] wr_data_i = 0, shared_bus_o, flash_bus, rd_data_o, ref_mem[int], wq[$], rq[$];
	int errors = 0, comparisons = 0, ks[$];
	wire ready_busy_n_i = !busy_pull;
	wire [7:0] shared_bus_i = shared_bus_oe_o ? shared_bus_o : flash_bus;
	nfc_host i_nfc_host (.*);
	nfc_flash_model i_nfc_flash_model (.cs_n_i(chip_select_n_o), .cle_i(command_latch_enable_o),
		.ale_i(address_latch_enable_o), .we_n_i(write_strobe_n_o),
		.output_strobe_n_i(output_strobe_n_o), .guard_n_i(program_guard_n_o),
		.shared_bus_i(shared_bus_i), .shared_bus_o(flash_bus), .busy_pull_o(busy_pull));
	always #10 clock_i = ~clock_i;
	// ==========================
	// write stream and read checks
	always @(negedge clock_i) begin
		if (took) void'(wq.pop_front());
		wr_valid_i = wq.size() > 0;
		wr_data_i = wr_valid_i ? wq[0] : 8'($urandom);
		#1 took = wr_valid_i && wr_ready_o;
	end
	always @(negedge clock_i) if (rd_valid_o === 1'b1) `CHK(rd_data_o, rq.pop_front())
	task automatic op(nfc_op_t o, int c, int r, int n, logic g);
		int t;
		int k;
		t = 0;
		req_op_i = o;
		req_col_i = 12'(c);
		req_row_i = 16'(r);
		req_len_i = 12'(n);
		guard_en_i = g;
		for (int i = 0; i < n; i++) begin
			k = r * 4096 + c + i;
			if (o == NFC_OP_PROG && !g) begin
				wq.push_back(8'($urandom));
				ref_mem[k] = wq[$];
			end
			if (o == NFC_OP_READ) rq.push_back(ref_mem.exists(k) ? ref_mem[k] : 8'hff);
		end
		if (o == NFC_OP_ERASE && !g) begin
			ks.delete();
			foreach (ref_mem[j]) if (j / 262144 == r / 64) ks.push_back(j);
			foreach (ks[j]) ref_mem.delete(ks[j]);
		end
		`CHK(req_ready_o, 1'b1)
		req_valid_i = 1;
		@(negedge clock_i) req_valid_i = 0;
		while (done_o !== 1'b1 && refused_o !== 1'b1 && t < 5000) begin
			@(negedge clock_i);
			t++;
		end
		`CHK(refused_o, g && o != NFC_OP_READ)
		@(negedge clock_i);
		`CHK(rq.size(), 0)
		`CHK(wq.size(), 0)
		`CHK(t < 5000, 1'b1)
	endtask
	task end_of_test;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		#1ms;
		$display("MISMATCH %0t watchdog expired", $time);
		errors++;
		end_of_test;
	end
	initial begin
		int c;
		int r;
		int n;
		void'($urandom(28103));
		repeat (12) @(negedge clock_i);
		rst_i = 0;
		@(negedge clock_i);
		for (int i = 0; i < 3; i++) begin
			n = $urandom_range(8, 1);
			c = i ? $urandom_range(2104) : 2112 - n;
			r = $urandom_range(65535);
			op(NFC_OP_PROG, c, r, n, 0);
			op(NFC_OP_READ, c, r, n, 0);
			op(NFC_OP_PROG, c, r, n, 1);
			op(NFC_OP_ERASE, c, r, 0, 1);
			op(NFC_OP_READ, c, r, n, 0);
			op(NFC_OP_ERASE, c, r, 0, 0);
			op(NFC_OP_READ, c, r, n, 0);
		end
		end_of_test;
	end
endmodule
